// ### design/fmrps_defines.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef FMRPS_DEFINES_SVH
`define FMRPS_DEFINES_SVH

// Frame layout of the 24-bit host frame
`define FMRPS_FRAME_BITS      24
`define FMRPS_RW_BIT          23
`define FMRPS_ADDR_HI         22
`define FMRPS_ADDR_LO         18
`define FMRPS_DATA_HI         17
`define FMRPS_DATA_LO         8
`define FMRPS_CRC_HI          7
`define FMRPS_CRC_LO          0

// Register addresses in the five-bit address field
`define FMRPS_ADDR_FAULT_STAT 5'h0e
`define FMRPS_ADDR_FAULT_MASK 5'h0f
`define FMRPS_ADDR_ROUTING    5'h10
`define FMRPS_ADDR_PIN_STATUS 5'h11

// Reset values and writable-bit masks
`define FMRPS_MASK_RESET      10'h0ec
`define FMRPS_ROUTE_RESET     10'h002
`define FMRPS_MASK_WRITABLE   10'h0fd
`define FMRPS_ROUTE_WRITABLE  10'h083

// Fault bit positions within the ten data bits
`define FMRPS_F_SELF_TEST     9
`define FMRPS_F_LOGIC_SUPPLY  8
`define FMRPS_F_DEADTIME      7
`define FMRPS_F_HOST_LINK     6
`define FMRPS_F_CONF_CRC      5
`define FMRPS_F_RT_MONITOR    4
`define FMRPS_F_WATCHDOG      3
`define FMRPS_F_INT_COMM      2
`define FMRPS_F_REF_UV        1
`define FMRPS_F_NEG_SUPPLY    0

// Faults that cannot be masked, and faults that stop switching
`define FMRPS_UNMASKABLE      10'h302
`define FMRPS_STOP_FAULTS     10'h33f

// Pin-status field positions
`define FMRPS_S_POR_LV        9
`define FMRPS_S_POR_HV        8

// Checksum of the host frame
`define FMRPS_CRC_POLY        8'h2f
`define FMRPS_CRC_INIT        8'hff

// Pin-status update bound and its cycle count at 40 MHz
`define FMRPS_CLK_MHZ         40
`define FMRPS_PIN_UPDATE_NS   1000
`define FMRPS_PIN_UPDATE_CYC  ((`FMRPS_PIN_UPDATE_NS * `FMRPS_CLK_MHZ) / 1000)

`endif

// ### design/fmrps_pkg.sv
// Types shared by the fault mask, routing and pin-status block
package fmrps_pkg;
    typedef logic [9:0] fmrps_data_t;
    typedef logic [4:0] fmrps_addr_t;
    typedef logic [6:0] fmrps_pins_t;
endpackage

// ### design/fmrps_top.sv
// Fault mask, interrupt routing and pin-status registers behind SPI frames
//
// What this block does
// - Mask bit 0 means fault neither latched, reported, nor stops switching; self-test, supply, reference undervoltage exempt.
// - Unmasked host frame or checksum error latches and reports, never stops.
// - Config checksum, monitor, comm, negative supply faults stop switching, clamp.
// - Masked watchdog keeps periodic conversion requests and never latches.
// - Watchdog fault raised when a periodic message gets no reply.
// - Watchdog fault mask resets to unmasked.
// - Routing bit 0 sends fault to B pin, 1 sends it to A pin.
// - Self-test and logic-supply faults report only on the B pin.
// - A pin shows faults only when report select sets it as fault output.
// - Routing bits accept writes only in configuration mode.
// - Routing bits 7, 1, 0; reset sends only reference undervoltage to A.
// - Routing at address 0x10, pin status at 0x11 in frame bits 22:18.
// - Pin status bits 15..9 give deglitched pin levels, 1 meaning high.
// - Pin-status bits follow a deglitched level change within 1 us.
// - Power-on recovery flags read 1 after reset or self-test; default 1.
// - Recovery flags clear on software reset or host writing 1.
// - Bit 17 flags low-voltage die recovery, bit 16 high-voltage die.
// - Monitor bit shows gate voltage when select is 0, collector when 1.
// - Monitor bit reads 1 when power device is on, 0 when off.
// - A pin status and monitor status may differ in fault mode.
// - Fault mask changes only in config mode; self-test, supply unmaskable.
`timescale 1ns/100ps
`include "fmrps_defines.svh"

module fmrps_top #(
    parameter int MSG_PERIOD_CYC  = 4000,
    parameter int REPLY_WAIT_CYC  = 1000
) (
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_b,
    // Host SPI pins
    input  wire logic              i_spi_sclk,
    input  wire logic              i_spi_cs_b,
    input  wire logic              i_spi_mosi,
    output logic                   o_spi_miso,
    // Mode and configuration inputs
    input  wire logic              i_config_mode,
    input  wire logic              i_realtime_report_select,
    input  wire logic              i_monitor_quantity_select,
    input  wire logic              i_miller_clamp_enable,
    input  wire logic              i_soft_reset,
    input  wire logic              i_self_test_done,
    // Fault events, one-cycle pulses in the fault bit layout
    input  wire fmrps_pkg::fmrps_data_t i_fault_event,
    // Cross-barrier message reply
    input  wire logic              i_hv_reply,
    // Pin levels from outside, in status order 15 down to 9
    input  wire fmrps_pkg::fmrps_pins_t i_pin_level,
    // Real-time monitor comparators
    input  wire logic              i_gate_voltage_high,
    input  wire logic              i_collector_voltage_high,
    // Fault and drive outputs
    output logic                   o_switch_disable,
    output logic                   o_low_side_gate_output,
    output logic                   o_active_miller_clamp,
    output logic                   o_interrupt_pin_main,
    output logic                   o_interrupt_pin_alt,
    output logic                   o_conversion_request
);
    import fmrps_pkg::*;

    localparam int SYNC_W = 10;

    logic [SYNC_W-1:0] sync_1;
    logic [SYNC_W-1:0] sync_2;
    logic [SYNC_W-1:0] sync_3;
    logic [SYNC_W-1:0] stable;
    logic [SYNC_W-1:0] stable_d;
    logic [SYNC_W-1:0] pin_raw;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              cs_fall;
    logic              cs_rise;
    logic [23:0]       rx_shift;
    logic [23:0]       tx_shift;
    logic [4:0]        bit_cnt;
    fmrps_addr_t       resp_addr;
    fmrps_data_t       fault_mask_second;
    fmrps_data_t       fault_interrupt_routing;
    fmrps_data_t       fault_status_second;
    logic              por_lv;
    logic              por_hv;
    logic              realtime_monitor_state;
    fmrps_data_t       resp_data;
    logic              frame_done;
    logic              frame_ok;
    logic              frame_write;
    fmrps_addr_t       frame_addr;
    fmrps_data_t       frame_data;
    fmrps_data_t       event_all;
    fmrps_data_t       clear_w1c;
    fmrps_data_t       routed_alt;
    logic [15:0]       period_cnt;
    logic [15:0]       wait_cnt;
    logic              waiting;
    logic              watchdog_event;
    logic              host_link_event;

    // Checksum over the sixteen header and data bits, MSB first
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = `FMRPS_CRC_INIT;
        for (int k = 15; k >= 0; k--) begin
            if (c[7] ^ d[k]) begin
                c = {c[6:0], 1'b0} ^ `FMRPS_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Three-stage synchronisers; a change counts once stages 2 and 3 agree
    assign pin_raw = {i_pin_level, i_spi_mosi, i_spi_cs_b, i_spi_sclk};
    generate
        for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_b) begin
                    sync_1[g] <= (g == 1) ? 1'b1 : 1'b0; // Idle level
                    sync_2[g] <= (g == 1) ? 1'b1 : 1'b0; // No false edge
                    sync_3[g] <= (g == 1) ? 1'b1 : 1'b0;
                    stable[g] <= (g == 1) ? 1'b1 : 1'b0;
                    stable_d[g] <= (g == 1) ? 1'b1 : 1'b0;
                end else begin
                    sync_1[g] <= pin_raw[g];
                    sync_2[g] <= sync_1[g];
                    sync_3[g] <= sync_2[g];
                    if (sync_2[g] == sync_3[g]) begin
                        stable[g] <= sync_3[g];
                    end
                    stable_d[g] <= stable[g];
                end
            end
        end
    endgenerate

    // Edges of the sampled link signals
    assign sclk_rise = stable[0] & ~stable_d[0];
    assign sclk_fall = ~stable[0] & stable_d[0];
    assign cs_fall   = ~stable[1] & stable_d[1];
    assign cs_rise   = stable[1] & ~stable_d[1];

    // Receive shifter and bit counter, sampled on rising clock edges
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            rx_shift <= 24'h000000;
            bit_cnt  <= 5'h00;
        end else if (cs_fall) begin
            bit_cnt <= 5'h00;
        end else if (!stable[1] && sclk_rise) begin
            rx_shift <= {rx_shift[22:0], stable[2]};
            if (bit_cnt != 5'h1f) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Frame decode at the end of a frame
    assign frame_done  = cs_rise;
    assign frame_ok    = (bit_cnt == 5'd`FMRPS_FRAME_BITS) &&
        (crc8(rx_shift[23:8]) == rx_shift[`FMRPS_CRC_HI:`FMRPS_CRC_LO]);
    assign frame_write = rx_shift[`FMRPS_RW_BIT];
    assign frame_addr  = rx_shift[`FMRPS_ADDR_HI:`FMRPS_ADDR_LO];
    assign frame_data  = rx_shift[`FMRPS_DATA_HI:`FMRPS_DATA_LO];
    assign host_link_event = frame_done & ~frame_ok;

    // Address of the register answered in the next frame
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            resp_addr <= `FMRPS_ADDR_PIN_STATUS;
        end else if (frame_done && frame_ok) begin
            resp_addr <= frame_addr;
        end
    end

    // Read multiplexer
    always_comb begin
        case (resp_addr)
            `FMRPS_ADDR_FAULT_STAT: resp_data = fault_status_second;
            `FMRPS_ADDR_FAULT_MASK: resp_data = fault_mask_second;
            `FMRPS_ADDR_ROUTING:    resp_data = fault_interrupt_routing;
            `FMRPS_ADDR_PIN_STATUS: resp_data = {por_lv, por_hv,
                stable[9:3], realtime_monitor_state};
            default:                resp_data = 10'h000;
        endcase
    end

    // Transmit shifter: answer loaded at frame start, shifted on falling edge
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            tx_shift <= 24'h000000;
        end else if (cs_fall) begin
            tx_shift <= {1'b0, resp_addr, resp_data,
                         crc8({1'b0, resp_addr, resp_data})};
        end else if (!stable[1] && sclk_fall) begin
            tx_shift <= {tx_shift[22:0], 1'b0};
        end
    end
    assign o_spi_miso = tx_shift[23];

    // Fault mask, writable only in configuration mode
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            fault_mask_second <= `FMRPS_MASK_RESET;
        end else if (frame_done && frame_ok && frame_write &&
                     frame_addr == `FMRPS_ADDR_FAULT_MASK &&
                     i_config_mode) begin
            fault_mask_second <= frame_data & `FMRPS_MASK_WRITABLE;
        end
    end

    // Interrupt routing, writable only in configuration mode
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            fault_interrupt_routing <= `FMRPS_ROUTE_RESET;
        end else if (frame_done && frame_ok && frame_write &&
                     frame_addr == `FMRPS_ADDR_ROUTING &&
                     i_config_mode) begin
            fault_interrupt_routing <= frame_data & `FMRPS_ROUTE_WRITABLE;
        end
    end

    // Periodic cross-barrier message and reply watchdog
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            period_cnt           <= 16'h0000;
            wait_cnt             <= 16'h0000;
            waiting              <= 1'b0;
            watchdog_event       <= 1'b0;
            o_conversion_request <= 1'b0;
        end else begin
            watchdog_event       <= 1'b0;
            o_conversion_request <= 1'b0;
            if (period_cnt == 16'(MSG_PERIOD_CYC - 1)) begin
                period_cnt <= 16'h0000;
                // Stop messaging only once a watchdog fault has latched
                if (!fault_status_second[`FMRPS_F_WATCHDOG]) begin
                    o_conversion_request <= 1'b1;
                    waiting              <= 1'b1;
                    wait_cnt             <= 16'h0000;
                end
            end else begin
                period_cnt <= period_cnt + 16'h0001;
            end
            if (waiting && i_hv_reply) begin
                waiting <= 1'b0;
            end else if (waiting &&
                         wait_cnt == 16'(REPLY_WAIT_CYC - 1)) begin
                waiting        <= 1'b0;
                watchdog_event <= 1'b1;
            end else if (waiting) begin
                wait_cnt <= wait_cnt + 16'h0001;
            end
        end
    end

    // Events from inputs and from the block's own detectors
    always_comb begin
        event_all = i_fault_event;
        event_all[`FMRPS_F_HOST_LINK] = host_link_event;
        event_all[`FMRPS_F_WATCHDOG]  = watchdog_event;
    end
    assign clear_w1c = (frame_done && frame_ok && frame_write &&
                        frame_addr == `FMRPS_ADDR_FAULT_STAT) ?
                       frame_data : 10'h000;

    // Latched faults: masked ones never latch, set beats clear
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            fault_status_second <= 10'h000;
        end else begin
            fault_status_second <= (fault_status_second & ~clear_w1c) |
                (event_all & (fault_mask_second | `FMRPS_UNMASKABLE));
        end
    end

    // Power-on recovery flags: set at reset or self-test, write-1 clear
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            por_lv <= 1'b1;
            por_hv <= 1'b1;
        end else if (i_self_test_done) begin
            por_lv <= 1'b1;
            por_hv <= 1'b1;
        end else if (i_soft_reset) begin
            por_lv <= 1'b0;
            por_hv <= 1'b0;
        end else if (frame_done && frame_ok && frame_write &&
                     frame_addr == `FMRPS_ADDR_PIN_STATUS) begin
            // Live pin bits are not stored, so writes cannot alter them
            if (frame_data[`FMRPS_S_POR_LV]) begin
                por_lv <= 1'b0;
            end
            if (frame_data[`FMRPS_S_POR_HV]) begin
                por_hv <= 1'b0;
            end
        end
    end

    // Real-time monitor state: 1 means the power device is on
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            realtime_monitor_state <= 1'b0;
        end else if (i_monitor_quantity_select) begin
            realtime_monitor_state <= ~i_collector_voltage_high;
        end else begin
            realtime_monitor_state <= i_gate_voltage_high;
        end
    end

    // Routing to the two interrupt outputs and switching shut-off
    assign routed_alt = fault_interrupt_routing & `FMRPS_ROUTE_WRITABLE &
                        {10{i_realtime_report_select}};
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_interrupt_pin_main   <= 1'b0;
            o_interrupt_pin_alt    <= 1'b0;
            o_switch_disable       <= 1'b0;
            o_low_side_gate_output <= 1'b0;
            o_active_miller_clamp  <= 1'b0;
        end else begin
            o_interrupt_pin_main <= |(fault_status_second & ~routed_alt);
            o_interrupt_pin_alt  <= |(fault_status_second & routed_alt);
            o_switch_disable       <= |(fault_status_second &
                                        `FMRPS_STOP_FAULTS);
            o_low_side_gate_output <= |(fault_status_second &
                                        `FMRPS_STOP_FAULTS);
            o_active_miller_clamp  <= i_miller_clamp_enable &
                |(fault_status_second & `FMRPS_STOP_FAULTS);
        end
    end

endmodule

// ### verification/fmrps_checker_assertions.sv
// Assertions on the drive, clamp and interrupt outputs
`timescale 1ns/100ps
module fmrps_checker #(
    parameter int MSG_PERIOD_CYC = 4000,
    parameter int REPLY_WAIT_CYC = 1000
) (
    // Clock and reset
    input wire logic                   i_core_clk,
    input wire logic                   i_rst_b,
    // Watched inputs
    input wire logic                   i_realtime_report_select,
    input wire logic                   i_miller_clamp_enable,
    input wire fmrps_pkg::fmrps_data_t i_fault_event,
    // Watched outputs
    input wire logic                   o_switch_disable,
    input wire logic                   o_low_side_gate_output,
    input wire logic                   o_active_miller_clamp,
    input wire logic                   o_interrupt_pin_main,
    input wire logic                   o_interrupt_pin_alt,
    input wire logic                   o_conversion_request
);
    import fmrps_pkg::*;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    // Steps of a fault from event to outputs
    sequence s_hard_hit;
        i_fault_event[9] || i_fault_event[8];
    endsequence
    sequence s_stop_on_b;
        o_switch_disable && o_interrupt_pin_main;
    endsequence
    sequence s_deadtime_only;
        (i_fault_event == 10'h080) && !o_switch_disable
        ##1 (i_fault_event == 10'h000);
    endsequence
    property p_hard_stop;
        s_hard_hit |-> ##2 s_stop_on_b;
    endproperty
    property p_gate_tracks;
        o_low_side_gate_output == o_switch_disable;
    endproperty
    property p_clamp;
        o_active_miller_clamp ==
            (o_switch_disable && $past(i_miller_clamp_enable));
    endproperty
    property p_alt_select;
        o_interrupt_pin_alt |-> $past(i_realtime_report_select);
    endproperty
    property p_stop_reported;
        o_switch_disable |-> o_interrupt_pin_main || o_interrupt_pin_alt;
    endproperty
    property p_req_pulse;
        o_conversion_request |-> ##1 (!o_conversion_request) [*8];
    endproperty
    property p_quiet;
        $rose(i_rst_b) |-> !(o_switch_disable || o_interrupt_pin_main
            || o_interrupt_pin_alt || o_conversion_request);
    endproperty
    property p_deadtime;
        s_deadtime_only |-> ##1 !o_switch_disable;
    endproperty
    // Checks
    a_hard_stop: assert property (p_hard_stop) else $error("no stop");
    a_gate_tracks: assert property (p_gate_tracks) else $error("gate");
    a_clamp: assert property (p_clamp) else $error("clamp");
    a_alt_select: assert property (p_alt_select) else $error("alt");
    a_stop_reported: assert property (p_stop_reported) else $error("rep");
    a_req_pulse: assert property (p_req_pulse) else $error("req");
    a_quiet: assert property (p_quiet) else $error("not idle");
    a_deadtime: assert property (p_deadtime) else $error("dt stop");
endmodule

bind fmrps_top fmrps_checker #(
    .MSG_PERIOD_CYC(MSG_PERIOD_CYC),
    .REPLY_WAIT_CYC(REPLY_WAIT_CYC)
) i_fmrps_checker (
    .i_core_clk, .i_rst_b, .i_realtime_report_select,
    .i_miller_clamp_enable, .i_fault_event, .o_switch_disable,
    .o_low_side_gate_output, .o_active_miller_clamp,
    .o_interrupt_pin_main, .o_interrupt_pin_alt, .o_conversion_request
);

// ### verification/fmrps_host_model.sv
// Host controller model that sends 24-bit frames and captures answers
`timescale 1ns/100ps
module fmrps_host_model (
    // Link pins
    output logic        o_sclk,
    output logic        o_cs_b,
    output logic        o_mosi,
    input  wire logic   i_miso,
    // Captured answer
    output logic [23:0] o_rx,
    output logic        o_rx_valid
);
    // Frame checksum, MSB first over command and data
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h2f : 8'h00);
        end
        return c;
    endfunction
    // Idle link: clock stands low, frame deselected
    initial begin
        {o_sclk, o_mosi, o_rx_valid} = 3'b000;
        o_cs_b = 1'b1;
        o_rx = 24'h000000;
    end
    // One frame; a set bad flag spoils the checksum
    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [9:0] d, input logic bad);
        logic [23:0] f;
        f = {w, a, d, 8'h00};
        f[7:0] = crc8(f[23:8]) ^ {7'h00, bad};
        o_cs_b = 1'b0;
        #200;
        for (int i = 23; i >= 0; i--) begin
            o_mosi = f[i];
            #100 o_sclk = 1'b1;
            // Device moves its bit some cycles after a fall: sample late
            #100 o_rx[i] = i_miso;
            o_sclk = 1'b0;
        end
        o_mosi = ~o_mosi; // Released line keeps no stale value
        #200 o_cs_b = 1'b1;
        o_rx_valid = 1'b1;
        #25 o_rx_valid = 1'b0;
        #400;
    endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the mask, routing and pin-status block
`timescale 1ns/100ps
module testbench;
    import fmrps_pkg::*;
    logic        clk, rst_b, cfg, rsel, msel, mce, srst, stdone, reply_en;
    logic        hv_reply, gh, ch, sclk, cs_b, mosi, miso, rx_valid;
    logic        sdis, gl, active_miller_clamp, int_b, int_a, req;
    logic [23:0] rx;
    logic [13:0] row;
    logic [10:0] exp_q[$];
    fmrps_data_t fev;
    fmrps_pins_t pins;
    int          error_cnt, check_count, n;
    // Rows {report select, event, alt, main, stop}
    logic [13:0] tbl [6] = '{14'h2404, 14'h2013, 14'h0402, 14'h2008,
                             14'h3003, 14'h2080};
    fmrps_top #(.MSG_PERIOD_CYC(50), .REPLY_WAIT_CYC(10)) i_dut (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_spi_sclk(sclk),
        .i_spi_cs_b(cs_b), .i_spi_mosi(mosi), .o_spi_miso(miso),
        .i_config_mode(cfg), .i_realtime_report_select(rsel),
        .i_monitor_quantity_select(msel), .i_miller_clamp_enable(mce),
        .i_soft_reset(srst), .i_self_test_done(stdone),
        .i_fault_event(fev), .i_hv_reply(hv_reply), .i_pin_level(pins),
        .i_gate_voltage_high(gh), .i_collector_voltage_high(ch),
        .o_switch_disable(sdis), .o_low_side_gate_output(gl),
        .o_active_miller_clamp(active_miller_clamp), .o_interrupt_pin_main(int_b),
        .o_interrupt_pin_alt(int_a), .o_conversion_request(req));
    fmrps_host_model i_host (.o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi),
        .i_miso(miso), .o_rx(rx), .o_rx_valid(rx_valid));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Far side answers each periodic request while reply_en is set
    always @(negedge clk) hv_reply <= reply_en && req;
    task automatic cmp_reg(input string s, input logic [9:0] e, g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic cmp_out(input string s, input logic e, g);
        cmp_reg(s, {9'h000, e}, {9'h000, g});
    endtask
    // Note the expected answer, then send the frame
    task automatic frame(input logic w, input logic [4:0] a,
        input logic [9:0] d, input logic c, input logic [9:0] e,
        input logic bad = 1'b0);
        exp_q.push_back({c, e});
        @(negedge clk);
        i_host.xfer(w, a, d, bad);
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Answer watcher takes the oldest note per frame
    initial begin
        logic [10:0] x;
        forever begin
            @(posedge rx_valid);
            x = (exp_q.size() > 0) ? exp_q.pop_front() : 11'h000;
            if (x[10]) cmp_reg("frame data", x[9:0], rx[17:8]);
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'hb85cf5de));
        {rst_b, cfg, rsel, msel, srst, stdone, ch} = 7'h00;
        {mce, reply_en, gh} = 3'b111;
        fev = 10'h000;
        pins = fmrps_pins_t'($urandom());
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
        frame(1'b0, 5'h0f, 10'h000, 1'b1, {2'b11, pins, 1'b1});
        frame(1'b1, 5'h10, 10'h081, 1'b1, 10'h0ec);
        frame(1'b0, 5'h10, 10'h000, 1'b1, 10'h002);
        cfg = 1'b1;
        msel = 1'b1;
        gh = 1'b0;
        frame(1'b1, 5'h10, 10'h081, 1'b0, 10'h000);
        frame(1'b0, 5'h11, 10'h000, 1'b1, 10'h081);
        cfg = 1'b0;
        pins = fmrps_pins_t'($urandom());
        repeat (40) @(negedge clk);
        frame(1'b1, 5'h11, 10'h3ff, 1'b1, {2'b11, pins, 1'b1});
        ch = 1'b1;
        frame(1'b0, 5'h11, 10'h000, 1'b1, {2'b00, pins, 1'b0});
        for (int k = 1; k >= 0; k--) begin
            @(negedge clk) {stdone, srst} = k ? 2'b10 : 2'b01;
            @(negedge clk) {stdone, srst} = 2'b00;
            frame(1'b0, 5'h11, 10'h000, 1'b1, {{2{k[0]}}, pins, 1'b0});
        end
        for (int k = 0; k < 6; k++) begin
            row = tbl[k];
            rsel = row[13];
            mce = k[0];
            @(negedge clk) fev = row[12:3];
            @(negedge clk) fev = 10'h000;
            repeat (2) @(negedge clk);
            cmp_out("alt pin", row[2], int_a);
            cmp_out("main pin", row[1], int_b);
            cmp_out("switch off", row[0], sdis);
            cmp_out("gate low", row[0], gl);
            cmp_out("clamp", row[0] & k[0], active_miller_clamp);
            frame(1'b1, 5'h0e, 10'h3ff, 1'b0, 10'h000);
        end
        frame(1'b0, 5'h10, 10'h000, 1'b0, 10'h000, 1'b1);
        cmp_out("main pin", 1'b1, int_b);
        cmp_out("switch off", 1'b0, sdis);
        frame(1'b1, 5'h0e, 10'h3ff, 1'b0, 10'h000);
        cfg = 1'b1;
        frame(1'b1, 5'h0f, 10'h0e4, 1'b0, 10'h000);
        cfg = 1'b0;
        reply_en = 1'b0;
        n = 0;
        repeat (200) @(negedge clk) n += req;
        cmp_out("requests", 1'b1, n >= 3);
        cmp_out("switch off", 1'b0, sdis);
        cfg = 1'b1;
        frame(1'b1, 5'h0f, 10'h0ec, 1'b0, 10'h000);
        cfg = 1'b0;
        n = 0;
        while (sdis !== 1'b1 && n < 200) @(negedge clk) n++;
        cmp_out("watchdog stop", 1'b1, sdis);
        frame(1'b0, 5'h0e, 10'h000, 1'b0, 10'h000);
        frame(1'b0, 5'h0e, 10'h000, 1'b1, 10'h008);
        repeat (10) @(negedge clk);
        finish_test();
    end
endmodule
